// *** rtl/npc_pkg.sv ***
// Package for the NOR protection and blank check command host controller.
package npc_pkg;

  // ****************************************************************
  // Register map of the controller (APB byte offsets)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ADDR    = 8'h04;
  localparam logic [7:0] REG_WDATA   = 8'h08;
  localparam logic [7:0] REG_RDATA   = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_IRQ_ST  = 8'h14;
  localparam logic [7:0] REG_IRQ_MSK = 8'h18;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_GO_LSB  = 0;
  localparam int CTRL_OP_LSB  = 4;
  localparam int CTRL_OP_W    = 4;
  localparam int CTRL_SET_LSB = 8;
  localparam int CTRL_SET_W   = 8;
  localparam int CTRL_X8_BIT  = 16;

  // Operations software can order.
  localparam logic [3:0] OP_ENTER    = 4'h0;
  localparam logic [3:0] OP_EXIT     = 4'h1;
  localparam logic [3:0] OP_EXIT_EXT = 4'h2;
  localparam logic [3:0] OP_PROG     = 4'h3;
  localparam logic [3:0] OP_READ     = 4'h4;
  localparam logic [3:0] OP_BLANK    = 4'h5;
  localparam logic [3:0] OP_CLR_NV   = 4'h6;
  localparam logic [3:0] OP_UNLOCK   = 4'h7;
  localparam logic [3:0] OP_RESET    = 4'h8;

  // ****************************************************************
  // Flash command codes and unlock addresses
  // ****************************************************************
  localparam logic [7:0]  CMD_AA      = 8'hAA;
  localparam logic [7:0]  CMD_55      = 8'h55;
  localparam logic [7:0]  CMD_LOCKREG = 8'h40;
  localparam logic [7:0]  CMD_PASSWD  = 8'h60;
  localparam logic [7:0]  CMD_NVBITS  = 8'hC0;
  localparam logic [7:0]  CMD_LOCKBIT = 8'h50;
  localparam logic [7:0]  CMD_VBITS   = 8'hE0;
  localparam logic [7:0]  CMD_EXTBLK  = 8'h88;
  localparam logic [7:0]  CMD_EXIT1   = 8'h90;
  localparam logic [7:0]  CMD_EXIT2   = 8'h00;
  localparam logic [7:0]  CMD_PROG    = 8'hA0;
  localparam logic [7:0]  CMD_ERASE1  = 8'h80;
  localparam logic [7:0]  CMD_ERASE2  = 8'h30;
  localparam logic [7:0]  CMD_BC_SET  = 8'hEB;
  localparam logic [7:0]  CMD_BC_SETB = 8'h76;
  localparam logic [7:0]  CMD_BC_CONF = 8'h29;
  localparam logic [7:0]  CMD_UNL1    = 8'h25;
  localparam logic [7:0]  CMD_UNL2    = 8'h03;
  localparam logic [7:0]  CMD_RESET   = 8'hF0;
  localparam logic [23:0] ADR_X8_A    = 24'h00_0AAA;
  localparam logic [23:0] ADR_X8_B    = 24'h00_0555;
  localparam logic [23:0] ADR_X16_A   = 24'h00_0555;
  localparam logic [23:0] ADR_X16_B   = 24'h00_02AA;
  localparam int          PWD_BYTES   = 8;

  // Status register bit that flags a failed blank check (DQ5).
  localparam int SR_ERR_BIT  = 5;
  localparam int SR_DONE_BIT = 7;

  // ****************************************************************
  // Bus timing (20 MHz, 50 ns clock)
  // ****************************************************************
  localparam int CLK_NS     = 50;
  localparam int T_STROBE_NS = 100;
  localparam int T_STROBE_CY =
      (T_STROBE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 : (T_STROBE_NS + CLK_NS - 1) / CLK_NS;

  // Interrupt status bits.
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_W     = 2;
endpackage

// *** rtl/npc_host.sv ***
// Host controller driving NOR flash protection and blank check sequences.
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module npc_host
  import npc_pkg::*;
#(
  parameter int AW = 24                     // Flash address width.
) (
  input  wire logic          pclk,          // System clock, 20 MHz.
  input  wire logic          presetn,       // Asynchronous reset, active low.
  input  wire logic          psel,          // APB select.
  input  wire logic          penable,       // APB enable.
  input  wire logic          pwrite,        // APB write.
  input  wire logic [7:0]    paddr,         // APB byte address.
  input  wire logic [31:0]   pwdata,        // APB write data.
  output logic      [31:0]   prdata,        // APB read data.
  output logic               pready,        // APB ready.
  output logic               pslverr,       // APB error on unmapped address.
  output logic               irq,           // Level interrupt.
  output logic [AW-1:0]      fl_addr,       // Flash address.
  output logic [15:0]        fl_dq_o,       // Flash data out.
  output logic               fl_dq_oe_n,    // Data enable, low while driving.
  input  wire logic [15:0]   fl_dq_i,       // Flash data in.
  output logic               fl_ce_n,       // Chip enable, active low.
  output logic               fl_oe_n,       // Output enable, active low.
  output logic               fl_we_n        // Write enable, active low.
);

  initial begin
    if (AW < 17) $error("AW too small for flash addressing");
  end

  // ****************************************************************
  // Sequence engine states
  // ****************************************************************
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_WSET = 6'b000010, S_WHLD = 6'b000100,
    S_RSET = 6'b001000, S_RHLD = 6'b010000, S_POLL = 6'b100000
  } npc_state_t;

  npc_state_t state_r;
  logic [3:0]  op_r;
  logic [7:0]  set_r;
  logic        x8_r;
  logic [AW-1:0] uaddr_r;
  logic [15:0] wdata_r, rdata_r;
  logic [3:0]  step_r;
  logic [3:0]  nsteps_r;
  logic [1:0]  tcnt_r;
  logic        busy_r, err_r, inset_r, poll_arm_r;
  logic [IRQ_W-1:0] ist_r, imsk_r;
  logic [2:0]  dq5_s, dq7_s;

  // ****************************************************************
  // APB slave decode
  // ****************************************************************
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire hit_ctl = paddr == REG_CTRL;
  wire mapped  = hit_ctl | (paddr == REG_ADDR) | (paddr == REG_WDATA) |
                 (paddr == REG_RDATA) | (paddr == REG_STATUS) |
                 (paddr == REG_IRQ_ST) | (paddr == REG_IRQ_MSK);
  wire go      = wr & hit_ctl & pwdata[CTRL_GO_LSB] & ~busy_r;
  wire [31:0] rd_mux =
      (paddr == REG_CTRL)    ? {15'h0, x8_r, set_r, op_r, 4'h0} :
      (paddr == REG_ADDR)    ? {{(32-AW){1'b0}}, uaddr_r} :
      (paddr == REG_WDATA)   ? {16'h0, wdata_r} :
      (paddr == REG_RDATA)   ? {16'h0, rdata_r} :
      (paddr == REG_STATUS)  ? {29'h0, inset_r, err_r, busy_r} :
      (paddr == REG_IRQ_ST)  ? {30'h0, ist_r} :
      (paddr == REG_IRQ_MSK) ? {30'h0, imsk_r} : 32'h0;

  // APB answers in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software fields; refused while busy, except the interrupt mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r    <= OP_ENTER;
      set_r   <= 8'h00;
      x8_r    <= 1'b0;
      uaddr_r <= '0;
      wdata_r <= 16'h0000;
      imsk_r  <= '0;
    end else begin
      if (go) begin
        op_r  <= pwdata[CTRL_OP_LSB +: CTRL_OP_W];
        set_r <= pwdata[CTRL_SET_LSB +: CTRL_SET_W];
        x8_r  <= pwdata[CTRL_X8_BIT];
      end
      if (wr && paddr == REG_ADDR && !busy_r) uaddr_r <= pwdata[AW-1:0];
      if (wr && paddr == REG_WDATA && !busy_r) wdata_r <= pwdata[15:0];
      if (wr && paddr == REG_IRQ_MSK) imsk_r <= pwdata[IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // Cycle table: address and data per step
  // ****************************************************************
  wire [23:0] ua   = x8_r ? ADR_X8_A : ADR_X16_A;
  wire [23:0] ub   = x8_r ? ADR_X8_B : ADR_X16_B;
  wire [3:0]  pidx = step_r - 4'd2;
  logic [AW-1:0] c_addr;
  logic [7:0]    c_data;
  logic          c_read;

  // Upper data byte is zero.
  always_comb begin
    c_addr = '0;
    c_data = 8'h00;
    c_read = 1'b0;
    case (op_r)
      OP_ENTER, OP_EXIT_EXT: begin
        case (step_r)
          4'd0: begin c_addr = AW'(ua); c_data = CMD_AA; end
          4'd1: begin c_addr = AW'(ub); c_data = CMD_55; end
          4'd2: begin
            c_addr = AW'(ua);
            c_data = (op_r == OP_ENTER) ? set_r : CMD_EXIT1;
          end
          default: c_data = CMD_EXIT2;
        endcase
      end
      OP_EXIT: c_data = (step_r == 4'd0) ? CMD_EXIT1 : CMD_EXIT2;
      OP_PROG: begin
        c_data = (step_r == 4'd0) ? CMD_PROG : wdata_r[7:0];
        c_addr = (step_r == 4'd0) ? '0 : uaddr_r;
      end
      OP_READ: begin
        c_addr = uaddr_r;
        c_read = 1'b1;
      end
      OP_BLANK: begin
        c_addr = uaddr_r;
        c_data = (step_r == 4'd0) ? CMD_BC_SET : CMD_BC_CONF;
      end
      OP_CLR_NV: c_data = (step_r == 4'd0) ? CMD_ERASE1 : CMD_ERASE2;
      OP_UNLOCK: begin
        case (step_r)
          4'd0: c_data = CMD_UNL1;
          4'd1: c_data = CMD_UNL2;
          4'd10: c_data = CMD_BC_CONF;
          default: begin
            c_addr = AW'(pidx[2:0]);
            c_data = (pidx[2:0] == uaddr_r[2:0]) ? wdata_r[7:0] : 8'h00;
          end
        endcase
      end
      OP_RESET: c_data = CMD_RESET;
      default: c_data = 8'h00;
    endcase
  end

  // Number of bus cycles per order.
  wire [3:0] nsteps_w =
      (op_r == OP_ENTER)   ? 4'd3 : (op_r == OP_EXIT_EXT) ? 4'd4 :
      (op_r == OP_UNLOCK)  ? 4'd11 : (op_r == OP_READ) ? 4'd1 :
      (op_r == OP_RESET)   ? 4'd1 : 4'd2;

  // ****************************************************************
  // Pin synchroniser for DQ5/DQ7 status (three stages)
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq5_s <= 3'b000;
      dq7_s <= 3'b000;
    end else begin
      dq5_s <= {dq5_s[1:0], fl_dq_i[SR_ERR_BIT]};
      dq7_s <= {dq7_s[1:0], fl_dq_i[SR_DONE_BIT]};
    end
  end
  wire dq7_ok = dq7_s[1] & dq7_s[2];
  wire dq5_ok = dq5_s[1] & dq5_s[2];

  // ****************************************************************
  // Sequence engine: one write or read strobe per step
  // ****************************************************************
  wire tdone  = tcnt_r == 2'(T_STROBE_CY - 1);
  wire last   = step_r == nsteps_r - 4'd1;
  wire ev_done = (state_r == S_POLL) & tdone & poll_arm_r & (dq7_ok | dq5_ok);
  wire ev_err  = ev_done & dq5_ok & ~dq7_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      step_r  <= 4'd0;
      nsteps_r <= 4'd1;
      tcnt_r  <= 2'd0;
      poll_arm_r <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      tcnt_r <= (state_r inside {S_IDLE, S_WSET, S_RSET} || tdone) ? 2'd0 : tcnt_r + 2'd1;
      // The first poll period still holds pre-read samples in the synchroniser.
      poll_arm_r <= (state_r == S_POLL) & (poll_arm_r | tdone);
      case (state_r)
        S_IDLE: if (go) begin
          busy_r   <= 1'b1;
          step_r   <= 4'd0;
          state_r  <= S_WSET;
        end
        S_WSET: begin
          nsteps_r <= nsteps_w;
          state_r  <= c_read ? S_RSET : S_WHLD;
        end
        S_WHLD: if (tdone) begin
          if (!last) begin
            step_r  <= step_r + 4'd1;
            state_r <= S_WSET;
          end else if (op_r == OP_BLANK) begin
            state_r <= S_POLL;
          end else begin
            state_r <= S_IDLE;
            busy_r  <= 1'b0;
          end
        end
        S_RSET: state_r <= S_RHLD;
        S_RHLD: if (tdone) begin
          state_r <= S_IDLE;
          busy_r  <= 1'b0;
        end
        S_POLL: if (ev_done) begin
          state_r <= S_IDLE;
          busy_r  <= 1'b0;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Pin drive, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_addr    <= '0;
      fl_dq_o    <= 16'h0000;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
      fl_we_n    <= 1'b1;
    end else begin
      fl_addr    <= c_addr;
      fl_dq_o    <= {8'h00, c_data};
      fl_dq_oe_n <= ~(state_r == S_WSET || state_r == S_WHLD) | c_read;
      fl_ce_n    <= state_r == S_IDLE;
      fl_we_n    <= ~(state_r == S_WHLD && !tdone); // Rises before the address moves.
      fl_oe_n    <= ~(state_r == S_RHLD || state_r == S_POLL);
    end
  end

  // Read capture, error and protection-set tracking.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 16'h0000;
      err_r   <= 1'b0;
      inset_r <= 1'b0;
    end else begin
      if ((state_r == S_RHLD || state_r == S_POLL) && tdone) rdata_r <= fl_dq_i;
      if (ev_err) err_r <= 1'b1;
      else if (go && pwdata[CTRL_OP_LSB +: CTRL_OP_W] == OP_RESET) err_r <= 1'b0;
      if (go && pwdata[CTRL_OP_LSB +: CTRL_OP_W] == OP_ENTER) inset_r <= 1'b1;
      else if (go && (pwdata[CTRL_OP_LSB +: CTRL_OP_W] == OP_EXIT ||
                      pwdata[CTRL_OP_LSB +: CTRL_OP_W] == OP_EXIT_EXT)) inset_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupts: sticky, write one to clear, set wins
  // ****************************************************************
  wire [IRQ_W-1:0] iset = {ev_err, ev_done};
  wire [IRQ_W-1:0] iclr = (wr && paddr == REG_IRQ_ST) ? pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      irq   <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~iclr) | iset;
      irq   <= |(((ist_r & ~iclr) | iset) & imsk_r);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_bc_order;
    @(posedge pclk) disable iff (!presetn)
      (op_r == OP_BLANK && state_r == S_WHLD && step_r == 4'd1) |-> c_data == CMD_BC_CONF;
  endproperty
  a_bc_order: assert property (p_bc_order) else $error("blank confirm wrong");

  property p_poll_read;
    @(posedge pclk) disable iff (!presetn)
      (state_r == S_POLL) |=> (fl_oe_n == 1'b0) || state_r == S_IDLE;
  endproperty
  a_poll_read: assert property (p_poll_read) else $error("poll not reading");

  property p_no_write_poll;
    @(posedge pclk) disable iff (!presetn)
      (state_r == S_POLL) |=> fl_we_n;
  endproperty
  a_no_write_poll: assert property (p_no_write_poll) else $error("write during check");

  property p_enter_code;
    @(posedge pclk) disable iff (!presetn)
      (op_r == OP_ENTER && state_r == S_WHLD && step_r == 4'd2) |-> c_data == set_r;
  endproperty
  a_enter_code: assert property (p_enter_code) else $error("enter code wrong");

  property p_exit_pair;
    @(posedge pclk) disable iff (!presetn)
      (op_r == OP_EXIT && state_r == S_WHLD) |-> c_data == (step_r == 4'd0 ? CMD_EXIT1 : CMD_EXIT2);
  endproperty
  a_exit_pair: assert property (p_exit_pair) else $error("exit data wrong");

  property p_unlock_len;
    @(posedge pclk) disable iff (!presetn)
      (op_r == OP_UNLOCK && state_r == S_WSET) |=> nsteps_r == 4'd11;
  endproperty
  a_unlock_len: assert property (p_unlock_len) else $error("unlock length wrong");

  property p_read_nowe;
    @(posedge pclk) disable iff (!presetn)
      (state_r == S_RHLD) |=> fl_we_n && fl_dq_oe_n;
  endproperty
  a_read_nowe: assert property (p_read_nowe) else $error("read drove bus");

  property p_err_hold;
    @(posedge pclk) disable iff (!presetn)
      $rose(err_r) |=> err_r [*2];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error dropped early");

  c_blank: cover property (@(posedge pclk) ev_done);
  c_err:   cover property (@(posedge pclk) ev_err);
  c_unl:   cover property (@(posedge pclk) op_r == OP_UNLOCK && last && state_r == S_WHLD);
endmodule
`default_nettype wire

// *** testbench/npc_flash_model.sv ***
// Flash model answering protection and blank check commands.
`timescale 1ns/1ps
`default_nettype none
module npc_flash_model #(
  parameter int BC_NS = 3000           // Blank check run time in ns.
) (
  input  wire logic [23:0] addr,       // Address from the host.
  input  wire logic [15:0] dq_w,       // Data driven by the host.
  input  wire logic        dq_oe_n,    // Host drive enable, low while driving.
  output logic      [15:0] dq_r,       // Data back to the host.
  input  wire logic        ce_n,       // Chip enable, active low.
  input  wire logic        oe_n,       // Output enable, active low.
  input  wire logic        we_n        // Write enable, active low.
);
  // ****************************************************************
  // Command state
  // ****************************************************************
  wire logic [7:0] wd = dq_w[7:0];
  wire logic [7:0] blk = addr[23:16];
  logic [7:0]   mode = 8'h00;
  logic [7:0]   pend = 8'h00;
  logic [7:0]   lockreg = 8'hFF;
  logic [7:0]   bc_blk = 8'h00;
  logic [63:0]  pwd = '1;
  logic [63:0]  ubuf = '0;
  logic [255:0] nvb = '1;
  logic [255:0] vb = '1;
  logic [255:0] dirty = 256'h8;
  logic         nvlock = 1'b1;
  logic         bc_busy = 1'b0;
  logic         bc_err = 1'b0;
  logic [15:0]  last = 16'h0000;
  int           step = 0;
  int           cnt = 0;
  event         bc_go;

  // Commands land as the write strobe closes.
  always @(posedge we_n) begin
    if (!ce_n && !bc_busy) begin
      if (bc_err) begin
        if (wd == 8'hF0) bc_err = 1'b0;
      end else if (pend == 8'hA0) begin
        case (mode)
          8'h40: lockreg = wd;
          8'h60: pwd[addr[2:0]*8 +: 8] = wd;
          8'hC0: if (nvlock) nvb[blk] = 1'b0;
          8'h50: nvlock = 1'b0;
          8'hE0: vb[blk] = wd[0];
          default: if (!(mode != 8'h00 && blk == 8'h00)) dirty[blk] = 1'b1;
        endcase
        pend = 8'h00;
      end else if (pend == 8'h80) begin
        if (wd == 8'h30 && mode == 8'hC0 && nvlock) nvb = '1;
        else if (wd == 8'h30 && mode == 8'h00 && dirty[blk]) dirty[blk] = 1'b0;
        pend = 8'h00;
      end else if (pend == 8'hEB) begin
        if (wd == 8'h29) -> bc_go;
        pend = 8'h00;
      end else if (pend == 8'h90) begin
        if (wd == 8'h00) mode = 8'h00;
        pend = 8'h00;
      end else if (pend == 8'h25) begin
        pend = (wd == 8'h03) ? 8'h03 : 8'h00;
        cnt = 0;
      end else if (pend == 8'h03 && cnt < 8) begin
        ubuf[addr[2:0]*8 +: 8] = wd;
        cnt++;
      end else if (pend == 8'h03) begin
        if (wd == 8'h29 && ubuf == pwd) nvlock = 1'b1;
        pend = 8'h00;
      end else if (step == 2) begin
        if (mode == 8'h00 && wd inside {8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0, 8'h88}) mode = wd;
        else if (wd == 8'h90) pend = 8'h90;
        step = 0;
      end else if (step == 1) begin
        step = (wd == 8'h55) ? 2 : 0;
      end else if (wd == 8'hAA && addr[11:0] inside {12'hAAA, 12'h555}) begin
        step = 1;
      end else if (wd inside {8'hA0, 8'h80, 8'hEB, 8'h76, 8'h90, 8'h25}) begin
        pend = (wd == 8'h76) ? 8'hEB : wd;
      end else begin
        pend = 8'h00;
      end
    end
  end

  // A check runs a fixed time, then ends clean or in error.
  always @(bc_go) begin
    bc_blk = blk;
    bc_busy = 1'b1;
    #(BC_NS);
    bc_err = dirty[bc_blk];
    bc_busy = 1'b0;
  end

  // Read data; a released bus shows the inverse of its last value.
  wire logic [15:0] rd = bc_busy ? 16'h0000 :
                         bc_err ? 16'h0020 :
                         mode == 8'h40 ? {8'h00, lockreg} :
                         mode == 8'h60 ? {8'h00, pwd[addr[2:0]*8 +: 8]} :
                         mode == 8'hC0 ? {15'h0000, nvb[blk]} :
                         mode == 8'h50 ? {15'h0000, nvlock} :
                         mode == 8'hE0 ? {15'h0000, vb[blk]} :
                         (mode != 8'h00 && blk == 8'h00) ? 16'h0000 :
                         dirty[blk] ? 16'h1234 : 16'hFFFF;
  assign dq_r = (!ce_n && !oe_n && dq_oe_n) ? rd : ~last;
  always @(posedge oe_n) last = rd;
endmodule
`default_nettype wire

// *** testbench/nor_protect_blank_check_cmds_bench.sv ***
// Self-checking bench for the NOR protection host controller.
`timescale 1ns/1ps
`default_nettype none
module nor_protect_blank_check_cmds_bench import npc_pkg::*;;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, irq, rde;
  logic [23:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic        fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n;
  int          miscompares = 0;
  int          n_compared = 0;
  int          k, ea[$], ed[$];
  logic [23:0] oa[$];
  logic [7:0]  od[$], b, lr;
  logic [7:0]  pw [8];
  logic [7:0]  codes [6] = '{CMD_LOCKREG, CMD_PASSWD, CMD_NVBITS,
                             CMD_LOCKBIT, CMD_VBITS, CMD_EXTBLK};

  npc_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n));
  npc_flash_model #(.BC_NS(3000)) flash_u (.addr(fl_addr), .dq_w(fl_dq_o),
    .dq_oe_n(fl_dq_oe_n), .dq_r(fl_dq_i), .ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n));

  // Free-running 20 MHz clock.
  initial begin
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask

  // Log each closing write strobe; data must be driven then.
  always @(posedge fl_we_n) begin
    if (presetn === 1'b1) begin
      oa.push_back(fl_addr);
      od.push_back(fl_dq_o[7:0]);
      chk({30'h0, fl_dq_oe_n, fl_ce_n}, 32'h0, "strobe");
    end
  end

  // One APB transfer, held until pready at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Expected writes; address -1 is not compared.
  task automatic ex(input int a, input int d);
    ea.push_back(a);
    ed.push_back(d);
  endtask
  task automatic exu(input logic x8, input logic [7:0] c);
    ex(x8 ? ADR_X8_A : ADR_X16_A, 8'hAA);
    ex(x8 ? ADR_X8_B : ADR_X16_B, 8'h55);
    ex(x8 ? ADR_X8_A : ADR_X16_A, c);
  endtask
  task automatic cmpq();
    chk(oa.size(), ea.size(), "write count");
    foreach (ea[i]) begin
      if (i < oa.size() && ea[i] >= 0) chk({8'h00, oa[i]}, ea[i], "write address");
      if (i < oa.size()) chk({24'h00_0000, od[i]}, ed[i], "write data");
    end
    oa.delete();
    od.delete();
    ea.delete();
    ed.delete();
  endtask

  // Bounded busy poll, then compare the logged writes.
  task automatic settle();
    int n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while (rdv[0] !== 1'b0 && n < 400);
    chk({31'h0, rdv[0]}, 32'h0, "busy stuck");
    cmpq();
  endtask
  task automatic op(input logic [3:0] o, input logic [7:0] s, input logic x8,
                    input logic [23:0] a, input logic [7:0] d, input logic fin);
    wr(REG_ADDR, {8'h00, a});
    wr(REG_WDATA, {24'h00_0000, d});
    wr(REG_CTRL, {15'h0000, x8, s, o, 4'h1});
    if (fin) settle();
  endtask
  task automatic enter(input logic [7:0] s, input logic x8);
    exu(x8, s);
    op(OP_ENTER, s, x8, 24'h00_0000, 8'h00, 1'b1);
    rd(REG_STATUS);
    chk({31'h0, rdv[2]}, 32'h1, "set flag");
  endtask
  task automatic leave(input logic [7:0] s, input logic x8);
    if (s == CMD_EXTBLK) exu(x8, CMD_EXIT1);
    else ex(-1, CMD_EXIT1);
    ex(-1, CMD_EXIT2);
    op(s == CMD_EXTBLK ? OP_EXIT_EXT : OP_EXIT, s, x8, 24'h00_0000, 8'h00, 1'b1);
    rd(REG_STATUS);
    chk({31'h0, rdv[2]}, 32'h0, "set flag");
  endtask
  task automatic prog(input logic [7:0] s, input logic x8, input logic [23:0] a,
                      input logic [7:0] d);
    ex(-1, CMD_PROG);
    ex(a, d);
    op(OP_PROG, s, x8, a, d, 1'b1);
  endtask
  task automatic rdf(input logic [7:0] s, input logic x8, input logic [23:0] a,
                     input logic [7:0] e);
    op(OP_READ, s, x8, a, 8'h00, 1'b1);
    rd(REG_RDATA);
    chk({24'h00_0000, rdv[7:0]}, {24'h00_0000, e}, "flash read");
  endtask

  task automatic conclude();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog, far above the run length.
  initial begin
    #2_000_000;
    miscompares++;
    conclude();
  end

  // Main sequence.
  initial begin
    void'($urandom(7020));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk(rdv, 32'h0000_0000, "reset value");
    end
    rd(8'h1C);
    chk({31'h0, rde}, 32'h1, "unmapped");
    foreach (codes[i]) begin
      enter(codes[i], i[0]);
      leave(codes[i], i[0]);
    end
    enter(CMD_LOCKREG, 1'b0);
    lr = 8'($urandom);
    prog(CMD_LOCKREG, 1'b0, 24'h00_0000, lr);
    rdf(CMD_LOCKREG, 1'b0, 24'h00_0000, lr);
    leave(CMD_LOCKREG, 1'b0);
    // Password written backwards, read forwards.
    enter(CMD_PASSWD, 1'b1);
    for (int j = 7; j >= 0; j--) begin
      pw[j] = 8'($urandom);
      prog(CMD_PASSWD, 1'b1, 24'(j), pw[j]);
    end
    for (int j = 0; j < PWD_BYTES; j++) rdf(CMD_PASSWD, 1'b1, 24'(j), pw[j]);
    k = $urandom_range(7);
    b = 8'($urandom);
    ex(0, CMD_UNL1);
    ex(0, CMD_UNL2);
    for (int j = 0; j < PWD_BYTES; j++) ex(j, j == k ? b : 0);
    ex(0, 8'h29);
    op(OP_UNLOCK, CMD_PASSWD, 1'b1, 24'(k), b, 1'b1);
    leave(CMD_PASSWD, 1'b1);
    // After the lock bit, nonvolatile bits stay fixed.
    enter(CMD_LOCKBIT, 1'b0);
    prog(CMD_LOCKBIT, 1'b0, 24'h12_3456, 8'h00);
    rdf(CMD_LOCKBIT, 1'b0, 24'h00_0000, 8'h00);
    leave(CMD_LOCKBIT, 1'b0);
    enter(CMD_NVBITS, 1'b0);
    ex(-1, CMD_ERASE1);
    ex(0, CMD_ERASE2);
    op(OP_CLR_NV, CMD_NVBITS, 1'b0, 24'h00_0000, 8'h00, 1'b1);
    prog(CMD_NVBITS, 1'b0, 24'h05_0010, 8'h00);
    rdf(CMD_NVBITS, 1'b0, 24'h05_0010, 8'h01);
    leave(CMD_NVBITS, 1'b0);
    enter(CMD_VBITS, 1'b0);
    for (int j = 0; j < 2; j++) begin
      prog(CMD_VBITS, 1'b0, 24'h06_0000, 8'(j));
      rdf(CMD_VBITS, 1'b0, 24'h06_0000, 8'(j));
    end
    leave(CMD_VBITS, 1'b0);
    // Clean check: done event, then clear.
    wr(REG_IRQ_MSK, 32'h0000_0003);
    ex(24'h02_0040, CMD_BC_SET);
    ex(24'h02_0040, CMD_BC_CONF);
    op(OP_BLANK, 8'h00, 1'b0, 24'h02_0040, 8'h00, 1'b1);
    rd(REG_STATUS);
    chk({30'h0, rdv[1:0]}, 32'h0, "clean check");
    rd(REG_IRQ_ST);
    chk({31'h0, rdv[0]}, 32'h1, "done event");
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(REG_IRQ_ST, 32'h0000_0003);
    rd(REG_IRQ_ST);
    chk(rdv, 32'h0000_0000, "w1c");
    chk({31'h0, irq}, 32'h0, "irq off");
    // Failing check, refused order, masked error.
    wr(REG_IRQ_MSK, 32'h0000_0000);
    ex(24'h03_0000, CMD_BC_SET);
    ex(24'h03_0000, CMD_BC_CONF);
    op(OP_BLANK, 8'h00, 1'b0, 24'h03_0000, 8'h00, 1'b0);
    wr(REG_CTRL, {24'h00_0000, OP_RESET, 4'h1});
    settle();
    rd(REG_STATUS);
    chk({31'h0, rdv[1]}, 32'h1, "check error");
    rd(REG_IRQ_ST);
    chk({31'h0, rdv[1]}, 32'h1, "error event");
    chk({31'h0, irq}, 32'h0, "masked");
    wr(REG_IRQ_MSK, 32'h0000_0002);
    rd(REG_STATUS);
    chk({31'h0, irq}, 32'h1, "unmasked");
    rdf(8'h00, 1'b0, 24'h05_0000, 8'h20);
    ex(-1, CMD_RESET);
    op(OP_RESET, 8'h00, 1'b0, 24'h00_0000, 8'h00, 1'b1);
    rdf(8'h00, 1'b0, 24'h03_0000, 8'h34);
    conclude();
  end
endmodule
`default_nettype wire
